// [rtl/ifc_pkg.sv]
`default_nettype none
package ifc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_MODE_CTRL = 8'hBF;
   localparam logic [7:0] IDX_OP_CTRL = 8'hC7;
   localparam logic [7:0] IDX_ADDR_HIGH = 8'hC0;
   localparam logic [7:0] IDX_ADDR_LOW = 8'hC1;
   localparam logic [7:0] IDX_DATA_BYTE = 8'hC2;
   localparam logic [7:0] IDX_UNLOCK = 8'hC3;
   localparam logic [7:0] IDX_STATUS = 8'hC4;
   // isp_mode_control fields
   localparam int MC_SOFT_RESET = 7;
   localparam int MC_RUN_BANK = 5;
   localparam int MC_AUX_RAM = 4;
   localparam int MC_ONE = 3;
   localparam int MC_LOADER_BOOT = 1;
   localparam int MC_PROG_EN = 0;
   localparam logic [7:0] MC_WRITE_MASK = 8'h93;
   localparam logic [7:0] MC_RESET = 8'h08;
   // flash_op_control fields
   localparam int OC_BANK = 6;
   localparam int OC_OE = 5;
   localparam int OC_CE = 4;
   localparam logic [7:0] OC_WRITE_MASK = 8'h7F;
   localparam logic [7:0] OC_RESET = 8'h30;
   // status fields
   localparam int ST_BUSY = 0;
   localparam int ST_PENDING = 1;
   // operation codes
   localparam logic [3:0] OP_ERASE = 4'h2;
   localparam logic [3:0] OP_PROG = 4'h1;
   localparam logic [3:0] OP_READ = 4'h0;
   // unlock codes
   localparam logic [7:0] UNLOCK_FIRST = 8'h87;
   localparam logic [7:0] UNLOCK_SECOND = 8'h59;
   // bank sizes in bytes
   localparam int APP_BANK_BYTES = 65536;
   localparam int LDR_BANK_BYTES = 4096;
   localparam int SOFT_RESET_CYCLES = 16;
   typedef enum logic [1:0] {UL_LOCKED = 2'b00, UL_HALF = 2'b01, UL_OPEN = 2'b11} ifc_unlock_e;
   typedef enum logic {FS_IDLE = 1'b0, FS_BUSY = 1'b1} ifc_flash_e;
endpackage
`default_nettype wire

// [rtl/ifc_isp_flash_control.sv]
// What this block does
// - two target banks: 64K application bank and 4K loader bank, either selectable.
// - normal operation fetches code from the application bank.
// - mode control writable only after unlock codes 87H then 59H.
// - any other unlock value closes mode control write access.
// - flash operations start only while the CPU idles; mode entry and exit happen only at idle wake-up.
// - program enable bit 0 set enters programming mode at next idle wake-up.
// - switching to the loader bank clears the program counter.
// - bits 0, 1 and 7 all set resets the CPU.
// - software reset returns registers, unlock state and fetch bank to power-on state; the flash sequencer is not reset.
// - writing 83H then idling and waking resets into the application bank.
// - flash address comes from high byte and low byte registers.
// - data byte supplies program data and receives read data.
// - op control bit 6 selects bank, bit 5 output enable, bit 4 chip enable.
// - ops 0010 erase, 0001 program, 0000 read with the matching enables.
// - mode control bit 5 is read-only and shows the running bank.
// - mode control bit 4 enables the auxiliary RAM.
`timescale 1ns/10ps
`default_nettype none
module ifc_isp_flash_control
   import ifc_pkg::*;
#(
   parameter int RESET_HOLD = SOFT_RESET_CYCLES
) (
   input wire logic REF_CLK_I,
   input wire logic RSTN_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic CPU_IDLE_I,
   output logic CPU_RESET_O,
   output logic PC_CLEAR_O,
   output logic FETCH_LOADER_BANK_O,
   output logic AUX_RAM_ENABLE_O,
   output logic FL_APP_SEL_O,
   output logic FL_LDR_SEL_O,
   output logic [3:0] FL_OP_O,
   output logic FL_CHIP_ENABLE_O,
   output logic FL_OUTPUT_ENABLE_O,
   output logic [15:0] FL_ADDR_O,
   output logic [7:0] FL_WDATA_O,
   output logic FL_REQ_O,
   input wire logic FL_DONE_I,
   input wire logic [7:0] FL_RDATA_I
);
   localparam logic [11:0] A_MODE = {2'b00, IDX_MODE_CTRL, 2'b00};
   localparam logic [11:0] A_OP = {2'b00, IDX_OP_CTRL, 2'b00};
   localparam logic [11:0] A_AH = {2'b00, IDX_ADDR_HIGH, 2'b00};
   localparam logic [11:0] A_AL = {2'b00, IDX_ADDR_LOW, 2'b00};
   localparam logic [11:0] A_DATA = {2'b00, IDX_DATA_BYTE, 2'b00};
   localparam logic [11:0] A_UNL = {2'b00, IDX_UNLOCK, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [15:0] LDR_MASK = 16'(LDR_BANK_BYTES - 1);
   localparam logic [15:0] APP_MASK = 16'(APP_BANK_BYTES - 1);
   localparam int RCW = $clog2(RESET_HOLD + 1);

   ifc_unlock_e unlock_q;
   ifc_flash_e fsm_q;
   logic [7:0] mode_q;
   logic [7:0] op_q;
   logic [7:0] addr_hi_q;
   logic [7:0] addr_lo_q;
   logic [7:0] data_q;
   logic run_loader_q;
   logic idle_q;
   logic pending_q;
   logic pc_clear_q;
   logic [RCW-1:0] rst_cnt_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic wr_en;
   logic wake;
   logic combo;
   logic soft_rst;
   logic op_legal;
   logic start;
   logic addr_ok;
   logic [7:0] rd_mux;

   // bus strobes and event decode
   assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
   assign wake = idle_q & ~CPU_IDLE_I;
   assign combo = mode_q[MC_SOFT_RESET] & mode_q[MC_LOADER_BOOT] & mode_q[MC_PROG_EN];
   assign soft_rst = wake & combo;
   assign start = pending_q & CPU_IDLE_I & run_loader_q & (fsm_q == FS_IDLE);
   assign PREADY_O = 1'b1;
   assign PRDATA_O = prdata_q;
   assign PSLVERR_O = pslverr_q;

   // legal operation codes with their enable pattern
   always_comb begin
      unique case (PWDATA_I[3:0])
         OP_ERASE, OP_PROG: op_legal = PWDATA_I[OC_OE] & ~PWDATA_I[OC_CE];
         OP_READ: op_legal = ~PWDATA_I[OC_OE] & ~PWDATA_I[OC_CE];
         default: op_legal = 1'b0;
      endcase
   end

   // read mux and address decode
   always_comb begin
      addr_ok = 1'b1;
      unique case (PADDR_I)
         A_MODE: rd_mux = {mode_q[7:6], run_loader_q, mode_q[4:0]};
         A_OP: rd_mux = op_q;
         A_AH: rd_mux = addr_hi_q;
         A_AL: rd_mux = addr_lo_q;
         A_DATA: rd_mux = data_q;
         A_UNL: rd_mux = 8'h00;
         A_ST: rd_mux = {6'h00, pending_q, fsm_q == FS_BUSY};
         default: begin
            rd_mux = 8'h00;
            addr_ok = 1'b0;
         end
      endcase
   end

   // read data and error registered in the setup phase
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (PSEL_I & ~PENABLE_I) begin
         prdata_q <= {24'h00_0000, rd_mux};
         pslverr_q <= ~addr_ok;
      end
   end

   // unlock sequence
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         unlock_q <= UL_LOCKED;
      end else if (soft_rst) begin
         unlock_q <= UL_LOCKED;
      end else if (wr_en && PADDR_I == A_UNL) begin
         if (PWDATA_I[7:0] == UNLOCK_FIRST) begin
            unlock_q <= UL_HALF;
         end else if (PWDATA_I[7:0] == UNLOCK_SECOND && unlock_q == UL_HALF) begin
            unlock_q <= UL_OPEN;
         end else begin
            unlock_q <= UL_LOCKED;
         end
      end
   end

   // mode control; bit 3 always one, reserved bits zero
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         mode_q <= MC_RESET;
      end else if (soft_rst) begin
         mode_q <= MC_RESET;
      end else if (wr_en && PADDR_I == A_MODE && unlock_q == UL_OPEN) begin
         mode_q <= (PWDATA_I[7:0] & MC_WRITE_MASK) | MC_RESET;
      end
   end

   // running bank, program counter clear and idle tracking
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         run_loader_q <= 1'b0;
         pc_clear_q <= 1'b0;
         idle_q <= 1'b0;
      end else begin
         idle_q <= CPU_IDLE_I;
         pc_clear_q <= 1'b0;
         if (soft_rst) begin
            run_loader_q <= 1'b0;
         end else if (wake && mode_q[MC_PROG_EN] && !run_loader_q) begin
            run_loader_q <= 1'b1;
            pc_clear_q <= 1'b1;
         end
      end
   end

   // stretched CPU reset after a software reset
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_cnt_q <= '0;
      end else if (soft_rst) begin
         rst_cnt_q <= RCW'(RESET_HOLD);
      end else if (rst_cnt_q != '0) begin
         rst_cnt_q <= rst_cnt_q - 1'b1;
      end
   end

   // address, data and op control registers
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         addr_hi_q <= 8'h00;
         addr_lo_q <= 8'h00;
         data_q <= 8'h00;
         op_q <= OC_RESET;
      end else if (soft_rst) begin
         addr_hi_q <= 8'h00;
         addr_lo_q <= 8'h00;
         data_q <= 8'h00;
         op_q <= OC_RESET;
      end else begin
         if (wr_en && PADDR_I == A_AH) addr_hi_q <= PWDATA_I[7:0];
         if (wr_en && PADDR_I == A_AL) addr_lo_q <= PWDATA_I[7:0];
         if (wr_en && PADDR_I == A_OP && fsm_q == FS_IDLE) op_q <= PWDATA_I[7:0] & OC_WRITE_MASK;
         if (fsm_q == FS_BUSY && FL_DONE_I && FL_OP_O == OP_READ) begin
            data_q <= FL_RDATA_I;
         end else if (wr_en && PADDR_I == A_DATA) begin
            data_q <= PWDATA_I[7:0];
         end
      end
   end

   // pending request: a legal op write while the sequencer idles arms it, any other such op write or the start clears it
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pending_q <= 1'b0;
      end else if (soft_rst) begin
         pending_q <= 1'b0;
      end else if (wr_en && PADDR_I == A_OP && fsm_q == FS_IDLE) begin
         pending_q <= op_legal;
      end else if (start) begin
         pending_q <= 1'b0;
      end
   end

   // flash sequencer drives the array from flip-flops
   always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         fsm_q <= FS_IDLE;
         FL_REQ_O <= 1'b0;
         FL_APP_SEL_O <= 1'b0;
         FL_LDR_SEL_O <= 1'b0;
         FL_OP_O <= OP_READ;
         FL_CHIP_ENABLE_O <= 1'b1;
         FL_OUTPUT_ENABLE_O <= 1'b1;
         FL_ADDR_O <= 16'h0000;
         FL_WDATA_O <= 8'h00;
      end else begin
         unique case (fsm_q)
            FS_IDLE: begin
               if (start) begin
                  fsm_q <= FS_BUSY;
                  FL_REQ_O <= 1'b1;
                  FL_APP_SEL_O <= ~op_q[OC_BANK];
                  FL_LDR_SEL_O <= op_q[OC_BANK];
                  FL_OP_O <= op_q[3:0];
                  FL_CHIP_ENABLE_O <= op_q[OC_CE];
                  FL_OUTPUT_ENABLE_O <= op_q[OC_OE];
                  if (op_q[3:0] == OP_ERASE) begin
                     FL_ADDR_O <= 16'h0000;
                     FL_WDATA_O <= 8'h00;
                  end else begin
                     FL_ADDR_O <= {addr_hi_q, addr_lo_q} & (op_q[OC_BANK] ? LDR_MASK : APP_MASK);
                     FL_WDATA_O <= data_q;
                  end
               end
            end
            FS_BUSY: begin
               if (FL_DONE_I) begin
                  fsm_q <= FS_IDLE;
                  FL_REQ_O <= 1'b0;
                  FL_APP_SEL_O <= 1'b0;
                  FL_LDR_SEL_O <= 1'b0;
                  FL_CHIP_ENABLE_O <= 1'b1;
                  FL_OUTPUT_ENABLE_O <= 1'b1;
               end
            end
         endcase
      end
   end

   // system-facing outputs
   assign CPU_RESET_O = rst_cnt_q != '0;
   assign PC_CLEAR_O = pc_clear_q;
   assign FETCH_LOADER_BANK_O = run_loader_q;
   assign AUX_RAM_ENABLE_O = mode_q[MC_AUX_RAM];

   // checks
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RSTN_I);

   // register access and unlock
   chk_mode_locked: assert property (
      (wr_en && PADDR_I == A_MODE && unlock_q != UL_OPEN && !soft_rst) |=> $stable(mode_q))
      else $error("mode control changed while locked");
   chk_unlock_order: assert property (
      (wr_en && PADDR_I == A_UNL && PWDATA_I[7:0] == UNLOCK_SECOND && unlock_q == UL_HALF && !soft_rst)
      |=> unlock_q == UL_OPEN)
      else $error("second unlock code did not open");
   chk_bad_code_locks: assert property (
      (wr_en && PADDR_I == A_UNL && PWDATA_I[7:0] != UNLOCK_FIRST && PWDATA_I[7:0] != UNLOCK_SECOND)
      |=> unlock_q == UL_LOCKED)
      else $error("bad unlock code left access open");
   chk_unlock_restart: assert property (
      (wr_en && PADDR_I == A_UNL && PWDATA_I[7:0] == UNLOCK_FIRST && !soft_rst) |=> unlock_q == UL_HALF)
      else $error("first unlock code did not arm");

   // flash sequencer and mode switching
   chk_op_idle_only: assert property (
      $rose(FL_REQ_O) |-> $past(CPU_IDLE_I) && run_loader_q)
      else $error("flash operation started outside idle");
   chk_wake_enters: assert property (
      (wake && mode_q[MC_PROG_EN] && !combo && !run_loader_q) |=> run_loader_q && PC_CLEAR_O ##1 !PC_CLEAR_O)
      else $error("wake-up did not enter programming mode");
   chk_soft_reset: assert property (
      soft_rst |=> CPU_RESET_O && !FETCH_LOADER_BANK_O && mode_q == MC_RESET && unlock_q == UL_LOCKED)
      else $error("software reset incomplete");
   chk_reset_hold: assert property (
      $rose(CPU_RESET_O) |-> CPU_RESET_O [*8])
      else $error("cpu reset too short");
   chk_read_capture: assert property (
      (fsm_q == FS_BUSY && FL_DONE_I && FL_OP_O == OP_READ && !soft_rst) |=> data_q == $past(FL_RDATA_I))
      else $error("read data not captured");
   chk_bank_sel: assert property (
      FL_REQ_O |-> (FL_LDR_SEL_O != FL_APP_SEL_O) && (!FL_LDR_SEL_O || FL_ADDR_O <= LDR_MASK))
      else $error("bank select or loader address wrong");
   chk_op_enables: assert property (
      FL_REQ_O |-> !FL_CHIP_ENABLE_O && (FL_OUTPUT_ENABLE_O == (FL_OP_O != OP_READ)))
      else $error("enable pattern does not match operation");
   chk_bad_op_refused: assert property (
      (wr_en && PADDR_I == A_OP && fsm_q == FS_IDLE && !op_legal && !soft_rst) |=> !pending_q)
      else $error("illegal operation left pending");
   chk_req_release: assert property (
      (FL_REQ_O && FL_DONE_I) |=> !FL_REQ_O && !FL_APP_SEL_O && !FL_LDR_SEL_O
      && FL_CHIP_ENABLE_O && FL_OUTPUT_ENABLE_O)
      else $error("flash outputs not released after done");
   chk_entry_at_wake: assert property (
      $rose(run_loader_q) |-> $past(wake) && $past(mode_q[MC_PROG_EN]))
      else $error("loader bank entered outside a wake-up");
   chk_aux_ram: assert property (
      (wr_en && PADDR_I == A_MODE && unlock_q == UL_OPEN && !soft_rst)
      |=> AUX_RAM_ENABLE_O == $past(PWDATA_I[MC_AUX_RAM]))
      else $error("aux ram enable mismatch");
   chk_mode_bit3: assert property (
      (PSEL_I && !PENABLE_I && PADDR_I == A_MODE)
      |=> PRDATA_O[MC_ONE] && PRDATA_O[MC_RUN_BANK] == $past(run_loader_q))
      else $error("mode control read-back wrong");

   // main scenarios reached
   cov_unlock_open: cover property (unlock_q == UL_HALF ##1 unlock_q == UL_OPEN);
   cov_enter_loader: cover property ($rose(run_loader_q));
   cov_flash_read: cover property (fsm_q == FS_BUSY && FL_DONE_I && FL_OP_O == OP_READ);
   cov_soft_reset: cover property (soft_rst);
   cov_op_refused: cover property (wr_en && PADDR_I == A_OP && fsm_q == FS_IDLE && !op_legal);
endmodule // ifc_isp_flash_control
`default_nettype wire

// [tb/ifc_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ifc_flash_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_i,
   input wire logic ldr_sel_i,
   input wire logic [3:0] op_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic slow_i,
   output logic done_o,
   output logic [7:0] rdata_o
);
   logic [7:0] app_q [0:65535];
   logic [7:0] ldr_q [0:4095];
   logic [4:0] cnt_q;
   // two banks, erase fills all ones; busy time short or long
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= 5'h00;
         done_o <= 1'b0;
         rdata_o <= 8'h00;
      end else begin
         done_o <= 1'b0;
         rdata_o <= ~rdata_o; // read data is only valid with done
         if (!req_i || done_o) begin
            cnt_q <= 5'h00;
         end else if (cnt_q == (slow_i ? 5'h14 : 5'h02)) begin
            done_o <= 1'b1;
            if (op_i == 4'h2 && ldr_sel_i) begin
               for (int i = 0; i < 4096; i++) ldr_q[i] <= 8'hFF;
            end else if (op_i == 4'h2) begin
               for (int i = 0; i < 65536; i++) app_q[i] <= 8'hFF;
            end else if (op_i == 4'h1 && ldr_sel_i) begin
               ldr_q[addr_i[11:0]] <= wdata_i;
            end else if (op_i == 4'h1) begin
               app_q[addr_i] <= wdata_i;
            end else if (ldr_sel_i) begin
               rdata_o <= ldr_q[addr_i[11:0]];
            end else begin
               rdata_o <= app_q[addr_i];
            end
         end else begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end
endmodule // ifc_flash_model
`default_nettype wire

// [tb/ifc_isp_flash_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module ifc_isp_flash_control_test;
   import ifc_pkg::*;
   localparam int HOLD = 8;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, cpu_rst, pc_clr, ldr_fetch, aux, app_sel, ldr_sel, ce, oe, req, done, serr;
   logic [3:0] op;
   logic [15:0] fadr;
   logic [7:0] fwd, frd;
   int err_total = 0, checks_done = 0, pc_pulses = 0, rst_cycles = 0;

   ifc_isp_flash_control #(.RESET_HOLD(HOLD)) i_ifc_isp_flash_control (.REF_CLK_I(clk), .RSTN_I(rstn),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CPU_IDLE_I(idle), .CPU_RESET_O(cpu_rst),
      .PC_CLEAR_O(pc_clr), .FETCH_LOADER_BANK_O(ldr_fetch), .AUX_RAM_ENABLE_O(aux), .FL_APP_SEL_O(app_sel),
      .FL_LDR_SEL_O(ldr_sel), .FL_OP_O(op), .FL_CHIP_ENABLE_O(ce), .FL_OUTPUT_ENABLE_O(oe),
      .FL_ADDR_O(fadr), .FL_WDATA_O(fwd), .FL_REQ_O(req), .FL_DONE_I(done), .FL_RDATA_I(frd));
   ifc_flash_model i_ifc_flash_model (.clk_i(clk), .rstn_i(rstn), .req_i(req), .ldr_sel_i(ldr_sel),
      .op_i(op), .addr_i(fadr), .wdata_i(fwd), .slow_i(slow), .done_o(done), .rdata_o(frd));

   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   // count settled pulse cycles
   always @(negedge clk) begin
      if (pc_clr === 1'b1) pc_pulses++;
      if (cpu_rst === 1'b1) rst_cycles++;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // one apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, pready);
      if (n >= 50) print_verdict();
   endtask

   task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(what, {24'h00_0000, exp}, rd);
   endtask

   task automatic wait_req(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (req !== v && n < 200);
      chk("flash request", v, req);
      if (req !== v) print_verdict();
   endtask

   // idle, wake, then let the result settle
   task automatic nap(input int cyc);
      @(posedge clk);
      idle <= 1'b1;
      repeat (cyc) @(posedge clk);
      idle <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // one flash operation from register setup to idle wake-up
   task automatic fop(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
      logic [15:0] ea;
      ea = (ctl[3:0] == OP_ERASE) ? 16'h0000 : (ctl[6] ? {4'h0, a[11:0]} : a);
      apb(1'b1, IDX_ADDR_HIGH, a[15:8]);
      apb(1'b1, IDX_ADDR_LOW, a[7:0]);
      apb(1'b1, IDX_DATA_BYTE, d);
      apb(1'b1, IDX_OP_CTRL, ctl);
      repeat (3) @(posedge clk);
      #1;
      chk("request while running", 0, req);
      @(posedge clk);
      idle <= 1'b1;
      wait_req(1'b1);
      chk("bank select", {ctl[6], !ctl[6]}, {ldr_sel, app_sel});
      chk("operation", ctl[3:0], op);
      chk("enables", {ctl[5], 1'b0}, {oe, ce});
      chk("address", ea, fadr);
      if (ctl[3:0] == OP_PROG) chk("write data", d, fwd);
      wait_req(1'b0);
      chk("enables idle", 2'b11, {oe, ce});
      @(posedge clk);
      idle <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      chk("run length", 0, 1);
      print_verdict();
   end

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rdchk("mode reset", IDX_MODE_CTRL, MC_RESET);
      rdchk("op reset", IDX_OP_CTRL, OC_RESET);
      chk("fetch bank", 0, ldr_fetch);
      $display("test reset values done");
      apb(1'b1, IDX_MODE_CTRL, 8'h11);
      rdchk("locked mode", IDX_MODE_CTRL, 8'h08);
      apb(1'b1, IDX_UNLOCK, UNLOCK_SECOND);
      apb(1'b1, IDX_UNLOCK, UNLOCK_FIRST);
      apb(1'b1, IDX_MODE_CTRL, 8'h11);
      rdchk("wrong order", IDX_MODE_CTRL, 8'h08);
      apb(1'b1, IDX_UNLOCK, UNLOCK_SECOND);
      apb(1'b1, IDX_MODE_CTRL, 8'h19);
      rdchk("open mode", IDX_MODE_CTRL, 8'h19);
      chk("aux ram", 1, aux);
      apb(1'b1, IDX_UNLOCK, 8'h00);
      apb(1'b1, IDX_MODE_CTRL, 8'h08);
      rdchk("relocked", IDX_MODE_CTRL, 8'h19);
      rdchk("unlock reads", IDX_UNLOCK, 8'h00);
      apb(1'b0, 8'h20, 8'h00);
      chk("unmapped error", 1, serr);
      apb(1'b1, IDX_UNLOCK, UNLOCK_FIRST);
      apb(1'b1, IDX_UNLOCK, UNLOCK_SECOND);
      chk("mapped error", 0, serr);
      $display("test write protection done");
      nap(5);
      chk("loader fetch", 1, ldr_fetch);
      chk("pc clear pulses", 1, pc_pulses);
      rdchk("running bank", IDX_MODE_CTRL, 8'h39);
      apb(1'b1, IDX_OP_CTRL, 8'h21);
      rdchk("op pending", IDX_STATUS, 8'h02);
      apb(1'b1, IDX_OP_CTRL, 8'h31);
      rdchk("illegal op refused", IDX_STATUS, 8'h00);
      $display("test mode entry done");
      fop(8'h21, 16'h1234, 8'hA5);
      fop(8'h61, 16'h0234, 8'h3C);
      fop(8'h00, 16'h1234, 8'h00);
      rdchk("app read", IDX_DATA_BYTE, 8'hA5);
      slow <= 1'b1;
      fop(8'h40, 16'hF234, 8'h00);
      rdchk("loader read", IDX_DATA_BYTE, 8'h3C);
      fop(8'h22, 16'h1234, 8'h77);
      slow <= 1'b0;
      fop(8'h00, 16'h1234, 8'h00);
      rdchk("erased read", IDX_DATA_BYTE, 8'hFF);
      $display("test flash operations done");
      apb(1'b1, IDX_MODE_CTRL, 8'h8B);
      repeat (3) @(posedge clk);
      chk("reset before idle", 0, rst_cycles);
      nap(10);
      repeat (HOLD + 4) @(posedge clk);
      chk("reset length", HOLD, rst_cycles);
      chk("fetch after reset", 0, ldr_fetch);
      chk("aux after reset", 0, aux);
      rdchk("mode after reset", IDX_MODE_CTRL, MC_RESET);
      apb(1'b1, IDX_MODE_CTRL, 8'h19);
      rdchk("relocked by reset", IDX_MODE_CTRL, MC_RESET);
      $display("test software reset done");
      print_verdict();
   end
endmodule // ifc_isp_flash_control_test
`default_nettype wire
